// file: hw/scs_regs.svh
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// parameter map, indexed by communication address
`define SCS_ADDR_MODE 16'h0101
`define SCS_ADDR_LOWPASS 16'h0106
`define SCS_ADDR_PRESET1 16'h0109
`define SCS_ADDR_PRESET2 16'h010a
`define SCS_ADDR_PRESET3 16'h010b
`define SCS_ADDR_ACCEL 16'h0122
`define SCS_ADDR_DECEL 16'h0123
`define SCS_ADDR_ROUND 16'h0124
`define SCS_ADDR_MAXSPD 16'h0128

`define SCS_RST_MODE 16'h0000
`define SCS_RST_LOWPASS 16'h0000
`define SCS_RST_PRESET 16'h0000
`define SCS_RST_ACCEL 16'h00c8
`define SCS_RST_DECEL 16'h00c8
`define SCS_RST_ROUND 16'h0000

`define SCS_MAX_MODE 16'h0003
`define SCS_MAX_LOWPASS 16'h03e8
`define SCS_MIN_RAMP 16'h0001
`define SCS_MAX_RAMP 16'h4e20
`define SCS_MAX_ROUND 16'h2710
`define SCS_MAX_RPM 16'h1388

// control sample tick of 1 ms, so every time setting counts ticks directly
`define SCS_TICK_NS 1000000
`define SCS_CLK_NS 40
`define SCS_TICK_CYCLES (`SCS_TICK_NS / `SCS_CLK_NS)

// speed and acceleration carry 16 fraction bits; analog full scale is 2^15
`define SCS_FRAC_W 16
`define SCS_ADC_SHIFT 15

`endif

// file: hw/scs_pkg.sv
package scs_pkg;

    typedef enum logic [1:0] {
        SCS_MODE_SPEED = 2'b00,
        SCS_MODE_SPEED_ZERO = 2'b01,
        SCS_MODE_TORQUE = 2'b10,
        SCS_MODE_TORQUE_ZERO = 2'b11
    } scs_mode_t;

    typedef enum logic [2:0] {
        SCS_SEQ_IDLE = 3'b000,
        SCS_SEQ_LP = 3'b001,
        SCS_SEQ_ACC = 3'b010,
        SCS_SEQ_JRK = 3'b011,
        SCS_SEQ_STEP = 3'b100
    } scs_seq_t;

    typedef logic signed [31:0] scs_q16_t;

endpackage : scs_pkg

// file: hw/scs_divider.sv
`timescale 1ns/10ps
// restoring divider, one quotient bit per clock
module scs_divider #(
    parameter int NUM_W = 32,
    parameter int DEN_W = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [NUM_W-1:0] num_i,
    input wire logic [DEN_W-1:0] den_i,
    output logic [NUM_W-1:0] quo_o,
    output logic done_o
);
    localparam int CNT_W = $clog2(NUM_W + 1);

    logic [DEN_W-1:0] rem_r;
    logic [DEN_W-1:0] den_r;
    logic [CNT_W-1:0] cnt_r;
    logic busy_r;
    logic [DEN_W:0] trial;

    if (NUM_W < 2 || DEN_W < 2) begin : g_chk
        $error("scs_divider widths too small");
    end

    assign trial = {rem_r, quo_o[NUM_W-1]};

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rem_r <= '0;
            den_r <= '0;
            quo_o <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin
            rem_r <= '0;
            den_r <= den_i;
            quo_o <= num_i;
            cnt_r <= CNT_W'(NUM_W);
            busy_r <= 1'b1;
            done_o <= 1'b0;
        end else if (busy_r) begin
            if (trial >= {1'b0, den_r}) begin
                rem_r <= DEN_W'(trial - {1'b0, den_r});
                quo_o <= {quo_o[NUM_W-2:0], 1'b1};
            end else begin
                rem_r <= trial[DEN_W-1:0];
                quo_o <= {quo_o[NUM_W-2:0], 1'b0};
            end
            cnt_r <= cnt_r - 1'b1;
            busy_r <= (cnt_r != 1);
            done_o <= (cnt_r == 1);
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule : scs_divider

// file: hw/scs_top.sv
`timescale 1ns/10ps
`include "scs_regs.svh"
// How it works
// - select 00, speed mode: analog voltage command
// - select 00, zero mode: command forced zero
// - select 01/10/11 picks preset one/two/three
// - new preset applies only after select change
// - contact off reads 0, on reads 1
// - same selection serves as torque-mode limit
// - three-segment S-curve shapes command changes
// - speed and acceleration both change continuously
// - accel time: zero to rated, 1-20000 ms
// - decel time: rated to zero, default 200
// - rounding time 0-10000 ms, default 0
// - rounding zero bypasses the ramp entirely
// - total ramp time is ramp plus rounding
// - analog command gets the same S-curve filter
// - low-pass time zero passes command through
// - analog command = volts times max speed / 10
module scs_top #(
    parameter int TICK_CYCLES = `SCS_TICK_CYCLES,
    parameter logic [15:0] RATED_RPM = 16'h0bb8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic speed_select_bit0_i,
    input wire logic speed_select_bit1_i,
    input wire logic signed [15:0] analog_cmd_i,
    input wire logic param_wr_i,
    input wire logic [15:0] param_addr_i,
    input wire logic [15:0] param_wdata_i,
    output logic [15:0] param_rdata_o,
    output logic param_err_o,
    output logic signed [15:0] speed_cmd_o,
    output logic speed_limit_mode_o
);
    import scs_pkg::*;

    localparam int TCNT_W = $clog2(TICK_CYCLES + 1);
    localparam logic [31:0] RATED_Q = {RATED_RPM, 16'h0000};

    if (TICK_CYCLES < 200 || RATED_RPM == 16'h0000 || RATED_RPM > `SCS_MAX_RPM) begin : g_chk
        $error("scs_top: tick too short for sequencer or rated speed out of range");
    end

    function automatic logic [32:0] mag33(input logic signed [32:0] v);
        mag33 = v[32] ? 33'(-v) : 33'(v);
    endfunction : mag33

    function automatic logic param_ok(input logic [15:0] a, input logic [15:0] d);
        logic signed [15:0] s;
        s = d;
        unique case (a)
            `SCS_ADDR_MODE: param_ok = d <= `SCS_MAX_MODE;
            `SCS_ADDR_LOWPASS: param_ok = d <= `SCS_MAX_LOWPASS;
            `SCS_ADDR_PRESET1, `SCS_ADDR_PRESET2, `SCS_ADDR_PRESET3:
                param_ok = (s <= $signed(`SCS_MAX_RPM)) && (s >= -$signed(`SCS_MAX_RPM));
            `SCS_ADDR_ACCEL, `SCS_ADDR_DECEL: param_ok = d >= `SCS_MIN_RAMP && d <= `SCS_MAX_RAMP;
            `SCS_ADDR_ROUND: param_ok = d <= `SCS_MAX_ROUND;
            `SCS_ADDR_MAXSPD: param_ok = d <= `SCS_MAX_RPM;
            default: param_ok = 1'b0;
        endcase
    endfunction : param_ok

    // parameter registers
    logic [1:0] mode_r;
    logic [15:0] lowpass_r;
    logic signed [15:0] preset_r [3];
    logic [15:0] accel_r;
    logic [15:0] decel_r;
    logic [15:0] round_r;
    logic [15:0] maxspd_r;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r <= 2'h0;
            lowpass_r <= `SCS_RST_LOWPASS;
            preset_r[0] <= `SCS_RST_PRESET;
            preset_r[1] <= `SCS_RST_PRESET;
            preset_r[2] <= `SCS_RST_PRESET;
            accel_r <= `SCS_RST_ACCEL;
            decel_r <= `SCS_RST_DECEL;
            round_r <= `SCS_RST_ROUND;
            maxspd_r <= RATED_RPM;
            param_err_o <= 1'b0;
        end else begin
            // out-of-range values are refused and the old setting kept
            param_err_o <= param_wr_i && !param_ok(param_addr_i, param_wdata_i);
            if (param_wr_i && param_ok(param_addr_i, param_wdata_i)) begin
                unique case (param_addr_i)
                    `SCS_ADDR_MODE: mode_r <= param_wdata_i[1:0];
                    `SCS_ADDR_LOWPASS: lowpass_r <= param_wdata_i;
                    `SCS_ADDR_PRESET1: preset_r[0] <= param_wdata_i;
                    `SCS_ADDR_PRESET2: preset_r[1] <= param_wdata_i;
                    `SCS_ADDR_PRESET3: preset_r[2] <= param_wdata_i;
                    `SCS_ADDR_ACCEL: accel_r <= param_wdata_i;
                    `SCS_ADDR_DECEL: decel_r <= param_wdata_i;
                    `SCS_ADDR_ROUND: round_r <= param_wdata_i;
                    `SCS_ADDR_MAXSPD: maxspd_r <= param_wdata_i;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            param_rdata_o <= 16'h0000;
        end else begin
            unique case (param_addr_i)
                `SCS_ADDR_MODE: param_rdata_o <= {14'h0000, mode_r};
                `SCS_ADDR_LOWPASS: param_rdata_o <= lowpass_r;
                `SCS_ADDR_PRESET1: param_rdata_o <= preset_r[0];
                `SCS_ADDR_PRESET2: param_rdata_o <= preset_r[1];
                `SCS_ADDR_PRESET3: param_rdata_o <= preset_r[2];
                `SCS_ADDR_ACCEL: param_rdata_o <= accel_r;
                `SCS_ADDR_DECEL: param_rdata_o <= decel_r;
                `SCS_ADDR_ROUND: param_rdata_o <= round_r;
                `SCS_ADDR_MAXSPD: param_rdata_o <= maxspd_r;
                default: param_rdata_o <= 16'h0000;
            endcase
        end
    end

    // select pins: three stages, accept once stages two and three agree
    logic [2:0] sync_r [2];
    logic [1:0] sel_stable_r;
    logic [1:0] sel_code_r;
    logic signed [15:0] preset_hold_r;

    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                sync_r[i] <= 3'h0;
                sel_stable_r[i] <= 1'b0;
            end else begin
                sync_r[i] <= {sync_r[i][1:0], (i == 0) ? speed_select_bit0_i : speed_select_bit1_i};
                if (sync_r[i][1] == sync_r[i][2]) begin
                    sel_stable_r[i] <= sync_r[i][2];
                end
            end
        end
    end

    // a preset is captured only on a select change, later writes wait for the next change
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_code_r <= 2'h0;
            preset_hold_r <= 16'sh0000;
        end else if (sel_stable_r != sel_code_r) begin
            sel_code_r <= sel_stable_r;
            preset_hold_r <= (sel_stable_r == 2'h0) ? 16'sh0000 : preset_r[sel_stable_r - 2'h1];
        end
    end
    // sample tick
    logic [TCNT_W-1:0] tick_cnt_r;
    logic tick_r;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == TCNT_W'(TICK_CYCLES - 1));
            tick_cnt_r <= (tick_cnt_r == TCNT_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
        end
    end

    // analog scaling: full-scale code stands for 10 V
    logic signed [32:0] analog_prod;
    assign analog_prod = analog_cmd_i * $signed({1'b0, maxspd_r});

    // sequencer and datapath
    scs_seq_t seq_r;
    logic started_r;
    logic div_start;
    logic [31:0] div_num;
    logic [15:0] div_den;
    logic [31:0] div_quo;
    logic div_done;
    logic is_analog_r;
    scs_q16_t x_r;
    scs_q16_t lp_r;
    scs_q16_t v_r;
    scs_q16_t a_r;
    logic [31:0] amax_r;
    logic [31:0] jerk_r;
    logic signed [32:0] lp_diff;
    logic signed [32:0] err;
    logic [32:0] abs_err;
    logic [32:0] abs_a;
    logic accelerating;
    logic [63:0] a_sq;
    logic [65:0] brake_lim;
    logic signed [32:0] a_dir;
    logic signed [32:0] a_dir_nxt;
    logic signed [32:0] a_nxt;
    logic signed [33:0] v_nxt;

    assign lp_diff = 33'(x_r) - 33'(lp_r);
    assign err = 33'(lp_r) - 33'(v_r);
    assign abs_err = mag33(err);
    assign abs_a = mag33(33'(a_r));
    assign accelerating = mag33(33'(lp_r)) > mag33(33'(v_r));
    assign a_sq = 64'(abs_a[31:0]) * 64'(abs_a[31:0]);
    assign brake_lim = 66'({jerk_r, 1'b0}) * 66'(abs_err);
    assign a_dir = err[32] ? -33'(a_r) : 33'(a_r);
    assign div_start = !started_r && (seq_r == SCS_SEQ_LP || seq_r == SCS_SEQ_ACC || seq_r == SCS_SEQ_JRK);

    always_comb begin
        div_num = RATED_Q;
        div_den = accelerating ? accel_r : decel_r;
        unique case (seq_r)
            SCS_SEQ_LP: begin
                div_num = 32'(mag33(lp_diff));
                div_den = lowpass_r;
            end
            SCS_SEQ_JRK: begin
                div_num = amax_r;
                div_den = round_r;
            end
            default: ;
        endcase
    end

    // jerk-limited step: accel builds over the rounding time, so total ramp is ramp plus rounding
    always_comb begin
        if (a_dir > 0 && 66'(a_sq) >= brake_lim) begin
            a_dir_nxt = (a_dir > 33'(jerk_r)) ? a_dir - 33'(jerk_r) : 33'sh0;
        end else begin
            a_dir_nxt = (a_dir + $signed(33'(jerk_r)) > $signed(33'(amax_r)))
                        ? 33'(amax_r) : a_dir + 33'(jerk_r);
        end
        a_nxt = err[32] ? -a_dir_nxt : a_dir_nxt;
        v_nxt = 34'(v_r) + 34'(a_nxt);
    end

    scs_divider #(
        .NUM_W(32),
        .DEN_W(16)
    ) u_div (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(div_start),
        .num_i(div_num),
        .den_i(div_den),
        .quo_o(div_quo),
        .done_o(div_done)
    );

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_r <= SCS_SEQ_IDLE;
            started_r <= 1'b0;
        end else begin
            started_r <= div_start || (started_r && !div_done);
            unique case (seq_r)
                SCS_SEQ_IDLE: if (tick_r) seq_r <= SCS_SEQ_LP;
                SCS_SEQ_LP: if (div_done) seq_r <= SCS_SEQ_ACC;
                SCS_SEQ_ACC: if (div_done) seq_r <= SCS_SEQ_JRK;
                SCS_SEQ_JRK: if (div_done) seq_r <= SCS_SEQ_STEP;
                SCS_SEQ_STEP: seq_r <= SCS_SEQ_IDLE;
                default: seq_r <= SCS_SEQ_IDLE;
            endcase
        end
    end

    // source select, latched at each tick with the mode read fresh
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            x_r <= 32'sh0;
            is_analog_r <= 1'b0;
            speed_limit_mode_o <= 1'b0;
        end else if (tick_r) begin
            speed_limit_mode_o <= mode_r[1];
            is_analog_r <= (sel_code_r == 2'h0) && !mode_r[0];
            if (sel_code_r != 2'h0) begin
                x_r <= {preset_hold_r, 16'h0000};
            end else if (mode_r[0]) begin
                x_r <= 32'sh0;
            end else begin
                x_r <= 32'(analog_prod <<< (`SCS_FRAC_W - `SCS_ADC_SHIFT));
            end
        end
    end

    // low-pass acts only on the analog source
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lp_r <= 32'sh0;
        end else if (seq_r == SCS_SEQ_LP && div_done) begin
            if (!is_analog_r || lowpass_r == 16'h0000) begin
                lp_r <= x_r;
            end else begin
                lp_r <= lp_diff[32] ? lp_r - $signed(div_quo) : lp_r + $signed(div_quo);
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            amax_r <= 32'h0;
            jerk_r <= 32'h0;
        end else if (div_done) begin
            if (seq_r == SCS_SEQ_ACC) begin
                amax_r <= div_quo;
            end
            if (seq_r == SCS_SEQ_JRK) begin
                jerk_r <= (div_quo == 32'h0) ? 32'h1 : div_quo;
            end
        end
    end

    // profiler serves every source, the analog path included
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            v_r <= 32'sh0;
            a_r <= 32'sh0;
            speed_cmd_o <= 16'sh0000;
        end else if (seq_r == SCS_SEQ_STEP) begin
            if (round_r == 16'h0000) begin
                v_r <= lp_r;
                a_r <= 32'sh0;
                speed_cmd_o <= lp_r[31:16];
            end else if ((abs_err <= 33'(jerk_r) && abs_a <= 33'(jerk_r))
                         || (err[32] ? v_nxt <= 34'(lp_r) : v_nxt >= 34'(lp_r))) begin
                v_r <= lp_r;
                a_r <= 32'sh0;
                speed_cmd_o <= lp_r[31:16];
            end else begin
                v_r <= v_nxt[31:0];
                a_r <= a_nxt[31:0];
                speed_cmd_o <= v_nxt[31:16];
            end
        end
    end
endmodule : scs_top

// file: tb/scs_top_asserts.sv
`timescale 1ns/10ps
`include "scs_regs.svh"
module scs_top_asserts #(
    parameter int TICK_CYCLES = 25000,
    parameter logic [15:0] RATED_RPM = 16'h0bb8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic param_wr_i,
    input wire logic [15:0] param_addr_i,
    input wire logic [15:0] param_wdata_i,
    input wire logic [15:0] param_rdata_o,
    input wire logic param_err_o,
    input wire logic signed [15:0] speed_cmd_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic wr_round;
    assign wr_round = param_wr_i && param_addr_i == `SCS_ADDR_ROUND;
    sequence s_round_wr; wr_round && param_wdata_i <= `SCS_MAX_ROUND; endsequence
    sequence s_round_rd; !param_wr_i && param_addr_i == `SCS_ADDR_ROUND; endsequence
    property p_round_err; wr_round && param_wdata_i > `SCS_MAX_ROUND |=> param_err_o; endproperty
    a_round_err: assert property (p_round_err) else $error("rounding write not refused");
    property p_round_ok; s_round_wr |=> !param_err_o; endproperty
    a_round_ok: assert property (p_round_ok) else $error("good rounding write refused");
    property p_round_back; s_round_wr ##1 s_round_rd |=> param_rdata_o == $past(param_wdata_i, 2); endproperty
    a_round_back: assert property (p_round_back) else $error("rounding readback wrong");
    property p_lp_err;
        param_wr_i && param_addr_i == `SCS_ADDR_LOWPASS && param_wdata_i > `SCS_MAX_LOWPASS |=> param_err_o;
    endproperty
    a_lp_err: assert property (p_lp_err) else $error("lowpass write not refused");
    property p_acc_err;
        param_wr_i && param_addr_i == `SCS_ADDR_ACCEL && (param_wdata_i == 16'h0000 || param_wdata_i > `SCS_MAX_RAMP)
        |=> param_err_o;
    endproperty
    a_acc_err: assert property (p_acc_err) else $error("accel write not refused");
    property p_pre_err;
        param_wr_i && param_addr_i == `SCS_ADDR_PRESET1
        && ($signed(param_wdata_i) > 5000 || $signed(param_wdata_i) < -5000) |=> param_err_o;
    endproperty
    a_pre_err: assert property (p_pre_err) else $error("preset write not refused");
    property p_err_cause; param_err_o |-> $past(param_wr_i); endproperty
    a_err_cause: assert property (p_err_cause) else $error("error pulse without write");
    property p_cmd_range; speed_cmd_o <= 5000 && speed_cmd_o >= -5000; endproperty
    a_cmd_range: assert property (p_cmd_range) else $error("speed command out of span");
    property p_tick_once; $changed(speed_cmd_o) |=> $stable(speed_cmd_o) [*8]; endproperty
    a_tick_once: assert property (p_tick_once) else $error("speed command moved twice in a tick");
endmodule : scs_top_asserts

bind scs_top scs_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .RATED_RPM(RATED_RPM)) i_scs_top_asserts (
    .mclk_i(mclk_i), .rst_i(rst_i), .param_wr_i(param_wr_i), .param_addr_i(param_addr_i),
    .param_wdata_i(param_wdata_i), .param_rdata_o(param_rdata_o), .param_err_o(param_err_o),
    .speed_cmd_o(speed_cmd_o));

// file: tb/scs_host_model.sv
`timescale 1ns/10ps
module scs_host_model (
    input wire logic mclk_i,
    input wire logic [15:0] param_rdata_i,
    input wire logic param_err_i,
    output logic param_wr_o,
    output logic [15:0] param_addr_o,
    output logic [15:0] param_wdata_o,
    output logic speed_select_bit0_o,
    output logic speed_select_bit1_o,
    output logic signed [15:0] analog_cmd_o
);
    initial begin
        {param_wr_o, speed_select_bit0_o, speed_select_bit1_o} = 3'b000;
        param_addr_o = 16'h0000;
        param_wdata_o = 16'hffff;
        analog_cmd_o = 16'sh0000;
    end
    task write(input logic [15:0] a, input logic [15:0] v, output logic e);
        @(posedge mclk_i);
        #1;
        param_wr_o = 1'b1;
        param_addr_o = a;
        param_wdata_o = v;
        @(posedge mclk_i);
        #1;
        param_wr_o = 1'b0;
        // released data must not look like the last word
        param_wdata_o = ~v;
        e = param_err_i;
    endtask : write
    task read(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        #1;
        param_addr_o = a;
        @(posedge mclk_i);
        #1;
        d = param_rdata_i;
    endtask : read
    task set_sel(input logic [1:0] c);
        @(posedge mclk_i);
        #1;
        {speed_select_bit1_o, speed_select_bit0_o} = c;
    endtask : set_sel
    task set_analog(input logic [15:0] v);
        @(posedge mclk_i);
        #1;
        analog_cmd_o = v;
    endtask : set_analog
endmodule : scs_host_model

// file: tb/speed_command_select_smoother_tb.sv
`timescale 1ns/10ps
`include "scs_regs.svh"
module speed_command_select_smoother_tb;
    import scs_pkg::*;
    localparam int TICK = 200;
    localparam int SETTLE = 2 * TICK + 200;
    typedef struct {logic [15:0] a; logic [15:0] v; logic e; logic [15:0] rd;} scs_row_t;
    scs_row_t rows [17] = '{
        '{`SCS_ADDR_ROUND, 16'h2710, 1'b0, 16'h2710}, '{`SCS_ADDR_ROUND, 16'h2711, 1'b1, 16'h2710},
        '{`SCS_ADDR_LOWPASS, 16'h03e8, 1'b0, 16'h03e8}, '{`SCS_ADDR_LOWPASS, 16'h03e9, 1'b1, 16'h03e8},
        '{`SCS_ADDR_ACCEL, 16'h4e20, 1'b0, 16'h4e20}, '{`SCS_ADDR_ACCEL, 16'h0000, 1'b1, 16'h4e20},
        '{`SCS_ADDR_ACCEL, 16'h4e21, 1'b1, 16'h4e20}, '{`SCS_ADDR_DECEL, 16'h0001, 1'b0, 16'h0001},
        '{`SCS_ADDR_DECEL, 16'h4e21, 1'b1, 16'h0001}, '{`SCS_ADDR_PRESET1, 16'hec78, 1'b0, 16'hec78},
        '{`SCS_ADDR_PRESET1, 16'hec77, 1'b1, 16'hec78}, '{`SCS_ADDR_PRESET2, 16'h1389, 1'b1, 16'h0000},
        '{`SCS_ADDR_MODE, 16'h0003, 1'b0, 16'h0003}, '{`SCS_ADDR_MODE, 16'h0004, 1'b1, 16'h0003},
        '{16'h0107, 16'h0005, 1'b1, 16'h0000}, '{`SCS_ADDR_MAXSPD, 16'h1389, 1'b1, 16'h0bb8},
        '{`SCS_ADDR_MAXSPD, 16'h1388, 1'b0, 16'h1388}};
    logic [15:0] pexp [3] = '{16'h03e8, 16'hf830, 16'h1388};
    logic [15:0] mexp [4] = '{16'h05dc, 16'h0000, 16'h05dc, 16'h0000};
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr, sel0, sel1, err, lim, e;
    logic [15:0] addr, wdata, rdata, d;
    logic signed [15:0] analog, cmd;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int v, prev, dv, dprev, n;
    always #20 mclk_i = ~mclk_i;
    scs_top #(.TICK_CYCLES(TICK)) i_scs_top (.mclk_i(mclk_i), .rst_i(rst_i), .speed_select_bit0_i(sel0),
        .speed_select_bit1_i(sel1), .analog_cmd_i(analog), .param_wr_i(wr), .param_addr_i(addr),
        .param_wdata_i(wdata), .param_rdata_o(rdata), .param_err_o(err), .speed_cmd_o(cmd),
        .speed_limit_mode_o(lim));
    scs_host_model i_scs_host_model (.mclk_i(mclk_i), .param_rdata_i(rdata), .param_err_i(err),
        .param_wr_o(wr), .param_addr_o(addr), .param_wdata_o(wdata), .speed_select_bit0_o(sel0),
        .speed_select_bit1_o(sel1), .analog_cmd_o(analog));
    task end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk
    task settle();
        repeat (SETTLE) @(posedge mclk_i);
        #2;
    endtask : settle
    task wr_ok(input logic [15:0] a, input logic [15:0] val);
        i_scs_host_model.write(a, val, e);
        chk("param_err_o", 16'h0000, {15'h0000, e});
    endtask : wr_ok
    task rd_chk(input logic [15:0] a, input logic [15:0] exp);
        i_scs_host_model.read(a, d);
        chk("reset value", exp, d);
    endtask : rd_chk
    task ramp(input logic signed [15:0] target, input int lo, input int hi);
        prev = cmd;
        dprev = 0;
        n = 0;
        // one speed update per sampling window, so steps are per-tick
        while (n < 200 && cmd !== target) begin
            repeat (TICK) @(posedge mclk_i);
            #2;
            v = cmd;
            dv = v - prev;
            chk("ramp step", 16'h0001, {15'h0000, dv <= 16 && dv >= -16});
            chk("ramp bend", 16'h0001, {15'h0000, dv - dprev <= 3 && dv - dprev >= -3});
            prev = v;
            dprev = dv;
            n++;
        end
        chk("ramp ticks", 16'h0001, {15'h0000, n >= lo && n <= hi});
    endtask : ramp
    always @(posedge mclk_i) begin
        cycles++;
        // ceiling well above the ramp scenario, the longest one
        if (cycles == 80000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        for (int i = 0; i < 17; i++) begin
            i_scs_host_model.write(rows[i].a, rows[i].v, e);
            chk("param_err_o", {15'h0000, rows[i].e}, {15'h0000, e});
            i_scs_host_model.read(rows[i].a, d);
            chk("param_rdata_o", rows[i].rd, d);
        end
        // second reset in mid-run, then defaults
        @(posedge mclk_i);
        #1;
        rst_i = 1'b1;
        repeat (2) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        chk("speed_cmd_o", 16'h0000, cmd);
        rd_chk(`SCS_ADDR_MODE, 16'h0000);
        rd_chk(`SCS_ADDR_LOWPASS, 16'h0000);
        rd_chk(`SCS_ADDR_ACCEL, 16'h00c8);
        rd_chk(`SCS_ADDR_DECEL, 16'h00c8);
        rd_chk(`SCS_ADDR_ROUND, 16'h0000);
        rd_chk(`SCS_ADDR_MAXSPD, 16'h0bb8);
        wr_ok(`SCS_ADDR_PRESET1, pexp[0]);
        wr_ok(`SCS_ADDR_PRESET2, pexp[1]);
        wr_ok(`SCS_ADDR_PRESET3, pexp[2]);
        for (int c = 1; c < 4; c++) begin
            i_scs_host_model.set_sel(c[1:0]);
            settle();
            chk("preset command", pexp[c-1], cmd);
        end
        // later preset writes wait for a select change
        wr_ok(`SCS_ADDR_PRESET3, 16'h0064);
        settle();
        chk("held preset", 16'h1388, cmd);
        i_scs_host_model.set_sel(2'b10);
        settle();
        i_scs_host_model.set_sel(2'b11);
        settle();
        chk("new preset", 16'h0064, cmd);
        i_scs_host_model.set_sel(2'b00);
        i_scs_host_model.set_analog(16'h4000);
        for (int m = 0; m < 4; m++) begin
            wr_ok(`SCS_ADDR_MODE, m[15:0]);
            settle();
            chk("analog command", mexp[m], cmd);
            chk("limit mode", {15'h0000, m[1]}, {15'h0000, lim});
        end
        wr_ok(`SCS_ADDR_LOWPASS, 16'h000a);
        wr_ok(`SCS_ADDR_MODE, 16'h0000);
        settle();
        chk("lowpass partial", 16'h0001, {15'h0000, cmd > 0 && cmd < 1500});
        wr_ok(`SCS_ADDR_LOWPASS, 16'h0000);
        settle();
        chk("lowpass bypass", 16'h05dc, cmd);
        wr_ok(`SCS_ADDR_MODE, 16'h0001);
        settle();
        wr_ok(`SCS_ADDR_ROUND, 16'h000a);
        wr_ok(`SCS_ADDR_PRESET1, 16'h05dc);
        i_scs_host_model.set_sel(2'b01);
        ramp(16'sd1500, 100, 125);
        // slower decel to a lower preset, so the decel time sets the ramp
        wr_ok(`SCS_ADDR_DECEL, 16'h012c);
        wr_ok(`SCS_ADDR_PRESET2, 16'h02ee);
        i_scs_host_model.set_sel(2'b10);
        ramp(16'sd750, 75, 100);
        end_of_test();
    end
endmodule : speed_command_select_smoother_tb
